// [io_chk.sv]
// port assertions for io_module_map, bound at the foot
`timescale 1ns/100ps
module io_chk (input wire logic mclk, srst, host_system_alarm, power_ok, output_common_supply, in_rd, out_wr,
    input wire logic [3:0] in_addr, driver_fault, driver_alarm, input wire logic [1:0] out_addr,
    input wire logic [7:0] in_data, out_wdata, pulse_count_1, input wire logic [31:0] output_pins);
default clocking @(posedge mclk); endclocking
default disable iff (srst);
a_alarm_off: assert property (host_system_alarm || !power_ok |=> !output_pins) else $error("alarm");
a_supply_off: assert property (!output_common_supply |=> !output_pins) else $error("supply");
a_fault_byte: assert property (driver_fault[2] |=> !output_pins[23:16]) else $error("fault");
a_alarm_copy: assert property (!$past(srst) |-> driver_alarm == $past(driver_fault)) else $error("copy");
a_read_alarm: assert property (in_rd && in_addr == 4'hf |=> in_data == {4'h0, $past(driver_alarm)}) else $error("ab");
a_read_unused: assert property (in_rd && in_addr inside {[4'h6:4'hb]} |=> !in_data) else $error("unused");
a_read_count: assert property (in_rd && in_addr == 4'hc |=> in_data == $past(pulse_count_1)) else $error("cnt");
a_write_pins: assert property (out_wr && out_addr == 2'h1 && !host_system_alarm && power_ok && output_common_supply
    && !driver_fault[1] |=> output_pins[15:8] == $past(out_wdata)) else $error("wr");
cover property (host_system_alarm); cover property (driver_fault[2]); cover property (in_rd && in_addr == 4'hf);
endmodule
bind io_module_map io_chk i_chk (.*);

// [io_host.sv]
// host link master model: one byte read or write per call
`timescale 1ns/100ps
module io_host (input wire logic mclk, output logic in_rd = '0, out_wr = '0, output logic [3:0] in_addr = '0,
    output logic [1:0] out_addr = '0, output logic [7:0] out_wdata = '0);
// offsets only: the block base is placed clear of the host's supervised bytes
// reads walk the whole 16-byte window, counter bytes too
task automatic rdb(logic [3:0] a); @(posedge mclk) in_rd <= '1; in_addr <= a; @(posedge mclk) in_rd <= '0; endtask
// whole byte per write, so paralleled bits switch together
task automatic wrb(logic [1:0] a, logic [7:0] d); @(posedge mclk) out_wr <= '1; out_addr <= a; out_wdata <= d;
    @(posedge mclk) out_wr <= '0; endtask
endmodule

// [io_map_defs.svh]
// constants for the polled digital i/o module: byte map, alarm byte layout
// assumes the link slave logic outside presents byte-wide input reads and output writes
// Contract
// - all outputs forced off on host system alarm or power loss.
// - input block spans 16 bytes, output block spans 4 bytes.
// - pulse generator counters one to three sit at input bytes 12, 13, 14.
// - driver overcurrent and overheat flags appear at input byte 15.
// - a faulting driver holds its whole output byte off until cause clears.
// - alarm bit k flags driver of output byte k; bits 4 to 7 reserved zero.
// - outputs on only while commanded and output common supply present.
// - a group holds at most one basic plus one expansion module.
`ifndef IO_MAP_DEFS_SVH
`define IO_MAP_DEFS_SVH
`define IN_BLOCK_BYTES 5'h10
`define OUT_BLOCK_BYTES 3'h4
`define IN_ADDR_W 4
`define OUT_ADDR_W 2
`define IN_GENERAL_LAST 4'h5
`define IN_UNUSED_FIRST 4'h6
`define IN_UNUSED_LAST 4'hb
`define PULSE_COUNTER_FIRST 4'hc
`define PULSE_COUNTER_SECOND 4'hd
`define PULSE_COUNTER_THIRD 4'he
`define OUTPUT_DRIVER_ALARM 4'hf
`define ALARM_RESERVED 4'h0
`define GROUP_MAX_MODULES 2'h2
`define BYTE_ZERO 8'h00
`define BYTE_BITS 8
`define OUT_BYTES 4
`endif

// [io_map_pkg.sv]
// types shared by the i/o module design
// assumes io_map_defs.svh supplies the numeric constants
package io_map_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] drv_flags_t;
    typedef struct packed {
        logic [31:0] out_cmd;
        drv_flags_t alarm;
        byte_t rd_data;
        logic [31:0] out_pins;
    } state_s;
endpackage

// [io_module_map.sv]
// digital i/o module: 16-byte input window, 4-byte output window, driver alarms
// assumes the link slave decodes the module's block and hands over byte offsets
`timescale 1ns/100ps
`include "io_map_defs.svh"
module io_module_map (
    input wire logic mclk, // 10 mhz clock
    input wire logic srst, // synchronous reset, high
    input wire logic [47:0] digital_input, // 48 general inputs, one module of a group
    input wire logic [7:0] pulse_count_1, // first pulse generator counter
    input wire logic [7:0] pulse_count_2, // second pulse generator counter
    input wire logic [7:0] pulse_count_3, // third pulse generator counter
    input wire logic [3:0] driver_fault, // per-byte overcurrent/overheat level
    input wire logic host_system_alarm, // host reports system alarm
    input wire logic power_ok, // host and module power present
    input wire logic output_common_supply, // output common supply present
    input wire logic in_rd, // input byte read strobe
    input wire logic [3:0] in_addr, // input byte offset
    output logic [7:0] in_data, // registered read data
    input wire logic out_wr, // output byte write strobe
    input wire logic [1:0] out_addr, // output byte offset
    input wire logic [7:0] out_wdata, // output byte value
    output logic [31:0] output_pins, // 32 driven outputs, 1 = on
    output logic [3:0] driver_alarm // live alarm flags per output byte
);
    io_map_pkg::state_s st_r; // registered state of the module
    io_map_pkg::state_s st_nxt; // next value of the state
    logic kill_all; // system alarm or power loss seen
    logic supply_lost; // output common supply opened
    logic [31:0] cmd_merged; // command word after this cycle's write
    logic [31:0] pins_faulted; // command word with faulting bytes held off
    io_map_pkg::byte_t rd_byte; // decoded input byte for this cycle's read

    // true for the offsets that carry the general inputs
    function automatic logic is_general(input logic [3:0] a);
        logic hit;
        hit = (a <= `IN_GENERAL_LAST);
        return hit;
    endfunction

    // true for the offsets that are left unused and read as zero
    function automatic logic is_unused(input logic [3:0] a);
        logic hit;
        hit = (a >= `IN_UNUSED_FIRST) && (a <= `IN_UNUSED_LAST);
        return hit;
    endfunction

    // alarm byte: live driver flags low, reserved bits forced to zero
    function automatic io_map_pkg::byte_t alarm_byte(input io_map_pkg::drv_flags_t al);
        io_map_pkg::byte_t v;
        v = {`ALARM_RESERVED, al};
        return v;
    endfunction

    // input window decode, offsets within the 16-byte block
    function automatic io_map_pkg::byte_t in_byte(input logic [3:0] a, input logic [47:0] di,
        input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3, input logic [3:0] al);
        io_map_pkg::byte_t v;
        v = `BYTE_ZERO;
        if (is_general(a))
            v = di[a*`BYTE_BITS +: `BYTE_BITS];
        else if (is_unused(a))
            v = `BYTE_ZERO;
        else if (a == `PULSE_COUNTER_FIRST)
            v = c1;
        else if (a == `PULSE_COUNTER_SECOND)
            v = c2;
        else if (a == `PULSE_COUNTER_THIRD)
            v = c3;
        else if (a == `OUTPUT_DRIVER_ALARM)
            v = alarm_byte(al);
        return v;
    endfunction

    // one written byte merged into the 32-bit command word
    function automatic logic [31:0] merge_cmd(input logic [31:0] cur, input logic [1:0] a,
        input io_map_pkg::byte_t d);
        logic [31:0] w;
        w = cur;
        w[a*`BYTE_BITS +: `BYTE_BITS] = d;
        return w;
    endfunction

    // one output byte as its driver presents it: a fault holds it off
    function automatic io_map_pkg::byte_t drive_byte(input io_map_pkg::byte_t cmd, input logic fault);
        io_map_pkg::byte_t v;
        v = cmd;
        if (fault)
            v = `BYTE_ZERO;
        return v;
    endfunction

    // every output byte through its own driver protection
    function automatic logic [31:0] gate_faults(input logic [31:0] cmd, input io_map_pkg::drv_flags_t flt);
        logic [31:0] w;
        w = cmd;
        for (int k = 0; k < `OUT_BYTES; k++)
        begin
            w[k*`BYTE_BITS +: `BYTE_BITS] = drive_byte(cmd[k*`BYTE_BITS +: `BYTE_BITS], flt[k]);
        end
        return w;
    endfunction

    // gating conditions taken straight from the pins
    assign kill_all = host_system_alarm || !power_ok;
    assign supply_lost = !output_common_supply;

    // this cycle's write, fault gating and read decode
    assign cmd_merged = out_wr ? merge_cmd(st_r.out_cmd, out_addr, out_wdata) : st_r.out_cmd;
    assign pins_faulted = gate_faults(cmd_merged, driver_fault);
    assign rd_byte = in_byte(in_addr, digital_input, pulse_count_1, pulse_count_2, pulse_count_3, st_r.alarm);

    // next state: commands, alarms, gated outputs
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.alarm = driver_fault; // clears as soon as the cause goes
        st_nxt.out_cmd = cmd_merged; // commands kept through a supply loss
        if (in_rd)
            st_nxt.rd_data = rd_byte; // held until the next read
        st_nxt.out_pins = pins_faulted;
        if (supply_lost)
            st_nxt.out_pins = '0;
        if (kill_all)
        begin
            st_nxt.out_pins = '0;
            st_nxt.out_cmd = '0; // commands dropped so outputs stay off after recovery
        end
        if (srst)
            st_nxt = '0;
    end

    // single state register
    always_ff @(posedge mclk)
    begin
        st_r <= st_nxt;
    end

    // outputs straight from the state flip-flops
    assign in_data = st_r.rd_data;
    assign output_pins = st_r.out_pins;
    assign driver_alarm = st_r.alarm;
endmodule

// [io_module_map_and_do_alarm_tb_top.sv]
// bench: host model on the link, field inputs set by nba at the rising edge
`timescale 1ns/100ps
module io_module_map_and_do_alarm_tb_top;
logic mclk = '0, srst = '1, host_system_alarm = '0, power_ok = '1, output_common_supply = '1, in_rd, out_wr, ok;
logic [47:0] digital_input = '0;
logic [7:0] pulse_count_1 = '0, pulse_count_2 = '0, pulse_count_3 = '0, in_data, out_wdata, x = 8'h49, e;
logic [3:0] driver_fault = '0, in_addr, driver_alarm;
logic [1:0] out_addr;
logic [31:0] output_pins, cmd = '0;
int fails = 0, compares = 0;
always #50 mclk = ~mclk;
io_host i_host (.*);
io_module_map i_dut (.*);
function automatic logic [7:0] nx(logic [7:0] v); return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]}; endfunction
task automatic chk(string n, logic [7:0] a, s); compares++;
    if (s !== a) begin fails++; $display("unexpected %s exp %h got %h", n, a, s); end endtask
task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
initial begin #300000 fails++; finish_test; end
// random field values, alarm, power, supply and fault patterns per test
initial
begin
    repeat (5) @(posedge mclk);
    srst <= '0;
    for (int i = 0; i < 30; i++)
    begin
        @(posedge mclk) x = nx(x);
        digital_input <= {6{x}} ^ 48'h0123456789ab; pulse_count_1 <= ~x; pulse_count_2 <= x ^ 8'h5a;
        pulse_count_3 <= x + 8'h7; driver_fault <= i % 5 ? '0 : x[3:0]; host_system_alarm <= i % 7 == 3;
        power_ok <= i % 11 != 5; output_common_supply <= i % 6 != 2; ok = !(i % 7 == 3 || i % 11 == 5);
        if (ok) begin i_host.wrb(2'(i), x); cmd[8 * (i % 4) +: 8] = x; end else cmd = '0;
        ok = ok && i % 6 != 2;
        repeat (2) @(posedge mclk);
        for (int k = 0; k < 16; k++)
        begin
            i_host.rdb(4'(k));
            e = k < 6 ? digital_input[8 * k +: 8] : k < 12 ? '0 : k < 15 ? 8'({pulse_count_3, pulse_count_2,
                pulse_count_1} >> 8 * (k - 12)) : {4'h0, driver_fault};
            #1 chk("in_data", e, in_data);
            if (k < 4) chk("pins", ok && !driver_fault[k] ? cmd[8 * k +: 8] : '0, output_pins[8 * k +: 8]);
            if (k == 15) chk("driver_alarm", {4'h0, driver_fault}, {4'h0, driver_alarm});
        end
        $display("test %0d done", i);
    end
    finish_test;
end
endmodule
